// ### inc/can_bt_pkg.sv
package can_bt_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_TIMING = 4'h0;
  localparam logic [3:0] OFF_CTRL   = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_COUNT  = 4'hC;

  // Timing register fields, each holding functional value minus one
  localparam int PRESC_LSB = 0;
  localparam int PRESC_W   = 6;
  localparam int STEP_LSB  = 6;
  localparam int STEP_W    = 2;
  localparam int PRE_LSB   = 8;
  localparam int PRE_W     = 4;
  localparam int POST_LSB  = 12;
  localparam int POST_W    = 3;
  localparam int TIMING_W  = 15;

  localparam logic [TIMING_W-1:0] TIMING_RST = 15'h2301;
  localparam logic [TIMING_W-1:0] TIMING_MASK = 15'h7FFF;

  // Control register
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b0;

  // Status register fields
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_SAMPLE_BIT = 1;
  localparam int ST_FRAME_BIT  = 2;
  localparam int ST_SYNCED_BIT = 3;
  localparam int ST_PE_LSB     = 8;
  localparam int ST_RES_LSB    = 16;

  // Count register fields
  localparam int CNT_W        = 16;
  localparam int CNT_HARD_LSB = 16;

  // Quantum counter and phase error widths
  localparam int TQ_W = 5;
  localparam int PE_W = 6;
  localparam logic [TQ_W-1:0] TQ_ONE  = 5'h01;
  localparam logic [TQ_W-1:0] TQ_ZERO = 5'h00;
  localparam logic [PE_W-1:0] PE_ZERO = 6'h00;

  // Bus level encoding
  localparam logic RECESSIVE = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SYNC  = 4'h2,
    ST_PRE_SAMPLE_SPAN = 4'h4,
    ST_POST_SAMPLE_SPAN = 4'h8
  } bt_state_t;

endpackage

// ### verilog/tq_prescaler.sv
module tq_prescaler #(
  parameter int W = 6
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] div_val,
  output logic              tq_tick
);

  logic [W-1:0] cnt_q;
  logic         tick_q;

  // Quantum is (div_val + 1) clock periods long
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= div_val)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tq_tick = tick_q;

endmodule

// ### verilog/can_bit_timing_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Each quantum compares bus level with level caught at previous sample.
// - Synchronize only on recessive previous sample and dominant quantum.
// - Edge in sync slot has zero error; else signed distance to slot end.
// - Hard sync restarts bit time at end of sync slot regardless of error.
// - Positive error lengthens early phase buffer by min(error, step limit).
// - Negative error shortens late phase buffer by min(error, step limit).
// - Early-edge resync skips the next sync slot.
// - Error beyond step limit stays as residual error.
// - At most one synchronization between two sample points.
// - Phase buffer changes apply to the current bit only.
// - One sample per bit, no majority filter.
// - Bit period runs from sample point to sample point.
// - Spike within step limit gets sampled past; larger one sampled dominant.
// - Bus is received whenever enabled, also while transmitting.
// - Quantum is clock divided by prescaler, 1 to 64.
// - Sync slot one quantum; pre segment 1 to 16, post segment 1 to 8; step limit 1 to 4.
// - Timing fields hold functional value minus one.
// - State machine steps once per quantum.
module can_bit_timing_sync (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        can_rx,
  input  wire logic        frame_active,
  output logic             sample_pulse,
  output logic             sample_bit,
  output logic             hard_sync_pulse,
  output logic             resync_pulse
);

  localparam int TQ_W = can_bt_pkg::TQ_W;
  localparam int PE_W = can_bt_pkg::PE_W;
  localparam int CW   = can_bt_pkg::CNT_W;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // Correction limited to step limit
  function automatic logic [TQ_W-1:0] clip(input logic [TQ_W-1:0] e,
                                           input logic [TQ_W-1:0] lim);
    clip = (e < lim) ? e : lim;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    merge = r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]                        rx_sync_q;
  logic                              rx_lvl;
  logic [can_bt_pkg::TIMING_W-1:0]   timing_q;
  logic                              enable_q;
  logic                              waitreq_q;
  logic [31:0]                       rdata_q;
  logic                              tq_tick;
  can_bt_pkg::bt_state_t             state_q;
  can_bt_pkg::bt_state_t             state_d;
  logic [TQ_W-1:0]                   cnt_q;
  logic [TQ_W-1:0]                   cnt_d;
  logic [TQ_W-1:0]                   ext_q;
  logic [TQ_W-1:0]                   ext_d;
  logic [TQ_W-1:0]                   shrink_q;
  logic [TQ_W-1:0]                   shrink_d;
  logic                              skip_q;
  logic                              skip_d;
  logic                              synced_q;
  logic                              synced_d;
  logic                              prev_q;
  logic                              sample_now;
  logic                              hard_now;
  logic                              resync_now;
  logic [PE_W-1:0]                   pe_q;
  logic [PE_W-1:0]                   pe_d;
  logic [TQ_W-1:0]                   resid_q;
  logic [TQ_W-1:0]                   resid_d;
  logic                              sample_pulse_q;
  logic                              sample_bit_q;
  logic                              hard_q;
  logic                              resync_q;
  logic [CW-1:0]                     n_resync_q;
  logic [CW-1:0]                     n_hard_q;
  logic [TQ_W-1:0]                   len1;
  logic [TQ_W-1:0]                   len2;
  logic [TQ_W-1:0]                   lim;
  logic                              edge_seen;
  logic [31:0]                       rd_mux;
  logic                              bus_go;

  //////////////////////////////////////////////////////////////////////////
  // Bus input synchronizer

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rx_sync_q <= {2{can_bt_pkg::RECESSIVE}};
    else
      rx_sync_q <= {rx_sync_q[0], can_rx};
  end

  // Single level per quantum, no filter
  assign rx_lvl = rx_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Field decode, functional lengths

  assign len1 = TQ_W'(timing_q[can_bt_pkg::PRE_LSB +: can_bt_pkg::PRE_W])
              + can_bt_pkg::TQ_ONE;
  assign len2 = TQ_W'(timing_q[can_bt_pkg::POST_LSB +: can_bt_pkg::POST_W])
              + can_bt_pkg::TQ_ONE;
  assign lim  = TQ_W'(timing_q[can_bt_pkg::STEP_LSB +: can_bt_pkg::STEP_W])
              + can_bt_pkg::TQ_ONE;

  tq_prescaler #(
    .W (can_bt_pkg::PRESC_W)
  ) u_presc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .div_val  (timing_q[can_bt_pkg::PRESC_LSB +: can_bt_pkg::PRESC_W]),
    .tq_tick  (tq_tick)
  );

  // Recessive at last sample, dominant now, not yet synced
  assign edge_seen = tq_tick && (prev_q == can_bt_pkg::RECESSIVE)
                   && (rx_lvl != can_bt_pkg::RECESSIVE)
                   && !synced_q;

  //////////////////////////////////////////////////////////////////////////
  // Bit timing state machine next state

  always_comb
  begin
    logic [TQ_W-1:0] e;
    logic [TQ_W-1:0] step;
    e          = can_bt_pkg::TQ_ZERO;
    step       = can_bt_pkg::TQ_ZERO;
    state_d    = state_q;
    cnt_d      = cnt_q;
    ext_d      = ext_q;
    shrink_d   = shrink_q;
    skip_d     = skip_q;
    synced_d   = synced_q;
    pe_d       = pe_q;
    resid_d    = resid_q;
    sample_now = 1'b0;
    hard_now   = 1'b0;
    resync_now = 1'b0;
    if (!enable_q)
    begin
      state_d  = can_bt_pkg::ST_IDLE;
      cnt_d    = can_bt_pkg::TQ_ZERO;
      ext_d    = can_bt_pkg::TQ_ZERO;
      shrink_d = can_bt_pkg::TQ_ZERO;
      skip_d   = 1'b0;
      synced_d = 1'b0;
    end
    else if (tq_tick)
    begin
      cnt_d = cnt_q + can_bt_pkg::TQ_ONE;
      unique case (state_q)
        can_bt_pkg::ST_IDLE:
        begin
          if (edge_seen)
          begin
            hard_now = 1'b1;
            state_d  = can_bt_pkg::ST_PRE_SAMPLE_SPAN;
            cnt_d    = can_bt_pkg::TQ_ZERO;
            synced_d = 1'b1;
            pe_d     = can_bt_pkg::PE_ZERO;
            resid_d  = can_bt_pkg::TQ_ZERO;
          end
        end
        can_bt_pkg::ST_SYNC:
        begin
          state_d = can_bt_pkg::ST_PRE_SAMPLE_SPAN;
          cnt_d   = can_bt_pkg::TQ_ZERO;
          if (edge_seen)
          begin
            hard_now   = !frame_active;
            resync_now = frame_active;
            synced_d   = 1'b1;
            pe_d       = can_bt_pkg::PE_ZERO;
            resid_d    = can_bt_pkg::TQ_ZERO;
          end
        end
        can_bt_pkg::ST_PRE_SAMPLE_SPAN:
        begin
          if (edge_seen && !frame_active)
          begin
            hard_now = 1'b1;
            cnt_d    = can_bt_pkg::TQ_ZERO;
            ext_d    = can_bt_pkg::TQ_ZERO;
            synced_d = 1'b1;
            pe_d     = PE_W'(cnt_q + can_bt_pkg::TQ_ONE);
            resid_d  = can_bt_pkg::TQ_ZERO;
          end
          else
          begin
            if (edge_seen)
            begin
              e          = cnt_q + can_bt_pkg::TQ_ONE;
              step       = clip(e, lim);
              ext_d      = step;
              resid_d    = e - step;
              pe_d       = PE_W'(e);
              resync_now = 1'b1;
              synced_d   = 1'b1;
            end
            if ((cnt_q + can_bt_pkg::TQ_ONE) >= (len1 + ext_d))
            begin
              sample_now = 1'b1;
              state_d    = can_bt_pkg::ST_POST_SAMPLE_SPAN;
              cnt_d      = can_bt_pkg::TQ_ZERO;
              ext_d      = can_bt_pkg::TQ_ZERO;
              synced_d   = 1'b0;
            end
          end
        end
        can_bt_pkg::ST_POST_SAMPLE_SPAN:
        begin
          if (edge_seen && !frame_active)
          begin
            hard_now = 1'b1;
            state_d  = can_bt_pkg::ST_PRE_SAMPLE_SPAN;
            cnt_d    = can_bt_pkg::TQ_ZERO;
            shrink_d = can_bt_pkg::TQ_ZERO;
            skip_d   = 1'b0;
            synced_d = 1'b1;
            pe_d     = can_bt_pkg::PE_ZERO - PE_W'(len2 - cnt_q);
            resid_d  = can_bt_pkg::TQ_ZERO;
          end
          else
          begin
            if (edge_seen)
            begin
              e          = len2 - cnt_q;
              step       = clip(e, lim);
              resid_d    = e - step;
              pe_d       = can_bt_pkg::PE_ZERO - PE_W'(e);
              resync_now = 1'b1;
              synced_d   = 1'b1;
              shrink_d   = step;
              skip_d     = 1'b1;
            end
            if ((cnt_q + can_bt_pkg::TQ_ONE) >= (len2 - shrink_d)
                || (edge_seen && e <= lim))
            begin
              state_d  = skip_d ? can_bt_pkg::ST_PRE_SAMPLE_SPAN
                                : can_bt_pkg::ST_SYNC;
              cnt_d    = can_bt_pkg::TQ_ZERO;
              shrink_d = can_bt_pkg::TQ_ZERO;
              skip_d   = 1'b0;
            end
          end
        end
        default:
        begin
          state_d = can_bt_pkg::ST_IDLE;
          cnt_d   = can_bt_pkg::TQ_ZERO;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State, counter and per-bit adjustments

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= can_bt_pkg::ST_IDLE;
      cnt_q   <= can_bt_pkg::TQ_ZERO;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_q    <= can_bt_pkg::TQ_ZERO;
      shrink_q <= can_bt_pkg::TQ_ZERO;
      skip_q   <= 1'b0;
      synced_q <= 1'b0;
    end
    else
    begin
      ext_q    <= ext_d;
      shrink_q <= shrink_d;
      skip_q   <= skip_d;
      synced_q <= synced_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample point

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_q         <= can_bt_pkg::RECESSIVE;
      sample_bit_q   <= can_bt_pkg::RECESSIVE;
      sample_pulse_q <= 1'b0;
    end
    else
    begin
      sample_pulse_q <= sample_now;
      if (!enable_q)
        prev_q <= can_bt_pkg::RECESSIVE;
      else if (sample_now)
      begin
        prev_q       <= rx_lvl;
        sample_bit_q <= rx_lvl;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sync reporting

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hard_q     <= 1'b0;
      resync_q   <= 1'b0;
      pe_q       <= can_bt_pkg::PE_ZERO;
      resid_q    <= can_bt_pkg::TQ_ZERO;
      n_resync_q <= '0;
      n_hard_q   <= '0;
    end
    else
    begin
      hard_q   <= hard_now;
      resync_q <= resync_now;
      pe_q     <= pe_d;
      resid_q  <= resid_d;
      if (resync_now)
        n_resync_q <= n_resync_q + 1'b1;
      if (hard_now)
        n_hard_q <= n_hard_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state

  assign bus_go = (avs_read || avs_write) && waitreq_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address, can_bt_pkg::OFF_TIMING))
      rd_mux[can_bt_pkg::TIMING_W-1:0] = timing_q;
    else if (hit(avs_address, can_bt_pkg::OFF_CTRL))
      rd_mux[can_bt_pkg::CTRL_EN_BIT] = enable_q;
    else if (hit(avs_address, can_bt_pkg::OFF_STATUS))
    begin
      rd_mux[can_bt_pkg::ST_RUN_BIT] = (state_q != can_bt_pkg::ST_IDLE);
      rd_mux[can_bt_pkg::ST_SAMPLE_BIT] = sample_bit_q;
      rd_mux[can_bt_pkg::ST_FRAME_BIT]  = frame_active;
      rd_mux[can_bt_pkg::ST_SYNCED_BIT] = synced_q;
      rd_mux[can_bt_pkg::ST_PE_LSB +: PE_W]  = pe_q;
      rd_mux[can_bt_pkg::ST_RES_LSB +: TQ_W] = resid_q;
    end
    else if (hit(avs_address, can_bt_pkg::OFF_COUNT))
    begin
      rd_mux[CW-1:0] = n_resync_q;
      rd_mux[can_bt_pkg::CNT_HARD_LSB +: CW] = n_hard_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      waitreq_q <= !bus_go;
      if (bus_go && avs_read)
        rdata_q <= rd_mux;
    end
  end

  // Writes land at the edge where waitrequest is seen low
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timing_q <= can_bt_pkg::TIMING_RST;
      enable_q <= can_bt_pkg::CTRL_EN_RST;
    end
    else if (avs_write && !waitreq_q)
    begin
      if (hit(avs_address, can_bt_pkg::OFF_TIMING))
        timing_q <= can_bt_pkg::TIMING_W'(merge(32'(timing_q),
                    avs_writedata, avs_byteenable));
      else if (hit(avs_address, can_bt_pkg::OFF_CTRL) && avs_byteenable[0])
        enable_q <= avs_writedata[can_bt_pkg::CTRL_EN_BIT];
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign sample_pulse    = sample_pulse_q;
  assign sample_bit      = sample_bit_q;
  assign hard_sync_pulse = hard_q;
  assign resync_pulse    = resync_q;

endmodule

// ### verif/can_bt_checker.sv
module can_bt_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic frame_active,
  input wire logic sample_pulse,
  input wire logic sample_bit,
  input wire logic hard_sync_pulse,
  input wire logic resync_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic seen_q;
  logic started_q;

  // Sync seen since last sample; first hard sync seen
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seen_q    <= 1'b0;
      started_q <= 1'b0;
    end
    else
    begin
      if (hard_sync_pulse || resync_pulse)
        seen_q <= 1'b1;
      else if (sample_pulse)
        seen_q <= 1'b0;
      if (hard_sync_pulse)
        started_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_hs_idle;
    hard_sync_pulse |-> !$past(frame_active);
  endproperty
  a_hs_idle: assert property (p_hs_idle)
    else $error("hard sync inside a frame");

  property p_rs_frame;
    resync_pulse |-> $past(frame_active);
  endproperty
  a_rs_frame: assert property (p_rs_frame)
    else $error("resync outside a frame");

  property p_sync_recessive;
    (hard_sync_pulse || resync_pulse) |-> sample_bit == can_bt_pkg::RECESSIVE;
  endproperty
  a_sync_recessive: assert property (p_sync_recessive)
    else $error("sync after dominant sample");

  property p_one_sync;
    (hard_sync_pulse || resync_pulse) |-> !seen_q;
  endproperty
  a_one_sync: assert property (p_one_sync)
    else $error("second sync between sample points");

  property p_hs_sample;
    hard_sync_pulse |-> ##[1:1000] sample_pulse;
  endproperty
  a_hs_sample: assert property (p_hs_sample)
    else $error("no sample after hard sync");

  property p_bit_held;
    $changed(sample_bit) |-> sample_pulse;
  endproperty
  a_bit_held: assert property (p_bit_held)
    else $error("sample bit changed off sample point");

  property p_after_start;
    sample_pulse |-> started_q;
  endproperty
  a_after_start: assert property (p_after_start)
    else $error("sample before first hard sync");

  property p_pulse_short;
    sample_pulse |=> !sample_pulse;
  endproperty
  a_pulse_short: assert property (p_pulse_short)
    else $error("sample pulse longer than one cycle");
endmodule

bind can_bit_timing_sync can_bt_checker can_bt_checker_inst (
  .core_clk,
  .resetn,
  .frame_active,
  .sample_pulse,
  .sample_bit,
  .hard_sync_pulse,
  .resync_pulse
);

// ### verif/can_bus_node.sv
module can_bus_node #(
  parameter int LAG = 1
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic dom_req,
  output logic      can_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [LAG-1:0] pipe_q;

  // Pulled-up bus, recessive when released; lag below pre span
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pipe_q <= '1;
    end
    else
    begin
      for (int i = LAG - 1; i > 0; i--)
      begin
        pipe_q[i] <= pipe_q[i - 1];
      end
      pipe_q[0] <= !dom_req;
    end
  end

  assign can_rx = pipe_q[LAG - 1];
endmodule

// ### verif/can_bit_timing_sync_test.sv
module can_bit_timing_sync_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAG = 1;

  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        can_rx;
  logic        frame_active = 1'b0;
  logic        dom_req = 1'b0;
  logic        sample_pulse;
  logic        sample_bit;
  logic        hard_sync_pulse;
  logic        resync_pulse;
  logic        rx_d = 1'b1;
  logic [31:0] rd;
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          edge_t = 0;
  int          sp_t = 0;
  int          sp_prev = 0;
  int          hs_t = 0;
  int          h_lag = 0;
  int          n_rs = 0;

  always #4 core_clk = ~core_clk;

  can_bit_timing_sync can_bit_timing_sync_inst (
    .core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .can_rx, .frame_active, .sample_pulse,
    .sample_bit, .hard_sync_pulse, .resync_pulse
  );

  can_bus_node #(.LAG(LAG)) can_bus_node_inst (
    .core_clk, .resetn, .dom_req, .can_rx
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event times and hang limit
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    rx_d <= can_rx;
    if (rx_d && !can_rx) edge_t <= cyc;
    if (sample_pulse) sp_t <= cyc;
    if (sample_pulse) sp_prev <= sp_t;
    if (hard_sync_pulse) hs_t <= cyc;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task next_sp;
    do @(posedge core_clk); while (sample_pulse !== 1'b1);
    @(negedge core_clk);
  endtask

  task wait_hs;
    do @(posedge core_clk); while (hard_sync_pulse !== 1'b1);
    @(negedge core_clk);
  endtask

  // Edge placed at quantum off after a recessive sample point
  task sync_case(input int off, input int hold, input int exp,
                 input logic b, input logic [5:0] pe);
    int p;
    int mag;
    do next_sp(); while (sample_bit !== 1'b1);
    p = sp_t;
    repeat (off - h_lag - LAG) @(posedge core_clk);
    dom_req <= 1'b1;
    repeat (hold) @(posedge core_clk);
    dom_req <= 1'b0;
    next_sp();
    chk("sample point", 32'(sp_t - p), 32'(exp));
    chk("sample bit", {31'h0, sample_bit}, {31'h0, b});
    next_sp();
    chk("next period", 32'(sp_t - sp_prev), 32'h8);
    bus(1'b0, can_bt_pkg::OFF_STATUS, 32'h0);
    mag = pe[5] ? 64 - int'(pe) : int'(pe);
    chk("phase error", {26'h0, rd[13:8]}, {26'h0, pe});
    chk("residual", {27'h0, rd[20:16]}, 32'(mag > 2 ? mag - 2 : 0));
    n_rs++;
    bus(1'b0, can_bt_pkg::OFF_COUNT, 32'h0);
    chk("resyncs", {16'h0, rd[15:0]}, 32'(n_rs));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b0, can_bt_pkg::OFF_TIMING, 32'h0);
    chk("timing", rd, 32'(can_bt_pkg::TIMING_RST));
    bus(1'b0, can_bt_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, can_bt_pkg::OFF_TIMING, 32'h0);
    chk("timing kept", rd, 32'(can_bt_pkg::TIMING_RST));
    // Edge while disabled must not start bit timing
    dom_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    dom_req <= 1'b0;
    bus(1'b0, can_bt_pkg::OFF_COUNT, 32'h0);
    chk("no sync idle", rd, 32'h0);
    // Reset timing: quantum 2 clocks, bit 8 quanta
    bus(1'b1, can_bt_pkg::OFF_CTRL, 32'h1);
    repeat (40) @(posedge core_clk);
    dom_req <= 1'b1;
    wait_hs();
    next_sp();
    chk("hs to sample", 32'(sp_t - hs_t), 32'h8);
    chk("hs bit", {31'h0, sample_bit}, 32'h0);
    @(posedge core_clk);
    dom_req <= 1'b0;
    next_sp();
    next_sp();
    chk("period", 32'(sp_t - sp_prev), 32'h10);
    bus(1'b0, can_bt_pkg::OFF_COUNT, 32'h0);
    chk("hard syncs", rd, 32'h10000);
    // Quantum 1 clock, limit 2, pre 4, post 3
    bus(1'b1, can_bt_pkg::OFF_CTRL, 32'h0);
    bus(1'b1, can_bt_pkg::OFF_TIMING, 32'h2340);
    bus(1'b1, can_bt_pkg::OFF_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    dom_req <= 1'b1;
    wait_hs();
    h_lag = hs_t - edge_t;
    next_sp();
    chk("hs to sample q1", 32'(sp_t - hs_t), 32'h4);
    @(posedge core_clk);
    dom_req <= 1'b0;
    frame_active <= 1'b1;
    sync_case(12, 4, 17, 1'b1, 6'h01);
    sync_case(13, 4, 18, 1'b1, 6'h02);
    sync_case(14, 4, 18, 1'b0, 6'h03);
    sync_case(11, 6, 16, 1'b0, 6'h00);
    sync_case(10, 6, 15, 1'b0, 6'h3F);
    sync_case(9, 6, 14, 1'b0, 6'h3E);
    sync_case(8, 6, 13, 1'b0, 6'h3D);
    // Edge in pre span with bus idle forces hard sync
    frame_active <= 1'b0;
    do next_sp(); while (sample_bit !== 1'b1);
    repeat (2) @(posedge core_clk);
    dom_req <= 1'b1;
    wait_hs();
    next_sp();
    chk("hs running", 32'(sp_t - hs_t), 32'h4);
    chk("hs running bit", {31'h0, sample_bit}, 32'h0);
    @(posedge core_clk);
    dom_req <= 1'b0;
    bus(1'b0, can_bt_pkg::OFF_COUNT, 32'h0);
    chk("all syncs", rd, {16'h0003, 16'(n_rs)});
    results();
  end
endmodule
